// *** inc/pfcdc_pkg.sv ***
// pfc digital control: shared constants, types and helpers
package pfcdc_pkg;

   // ********************************
   // timing
   // ********************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned FIXED_RATE_HZ = 6_500;
   localparam int unsigned FIXED_RATE_CYC = CLK_HZ / FIXED_RATE_HZ;
   localparam int unsigned SWITCH_HZ = 65_000;
   localparam int unsigned SWITCH_CYC = CLK_HZ / SWITCH_HZ;
   localparam int unsigned DUTY_MAX_PCT = 95;
   // shortest on-time loaded in run, in clock cycles
   localparam logic [15:0] DUTY_MIN = 16'h0001;
   localparam logic [7:0] RELAY_SETTLE_TICKS = 8'h41;

   // ********************************
   // scaling: currents in A, volts in V, 4 fraction bits
   // ********************************
   localparam logic [15:0] CUR_SEG_SPLIT = 16'h00F0;
   localparam logic [15:0] BW_SWITCH_RST = 16'h0060;
   localparam logic [15:0] BW_HYST_RST = 16'h0010;
   localparam logic [15:0] RELAY_OPEN_RST = 16'h14D0;
   localparam logic [15:0] K_ONE = 16'h4000;
   localparam int K_FRAC = 14;
   localparam int G_FRAC = 12;
   localparam logic [15:0] G_ONE = 16'h1000;
   localparam logic [15:0] G_MIN = 16'h0400;
   localparam logic [15:0] SEG_A_SLOPE = 16'h0020;
   localparam logic [15:0] SEG_B_BASE = 16'h0E20;
   localparam logic [15:0] SEG_B_SLOPE = 16'h0050;
   localparam logic [15:0] KP_HI_BW = 16'h0900;
   localparam logic [15:0] KI_HI_BW = 16'h0120;
   localparam logic [15:0] KP_LO_BW = 16'h0500;
   localparam logic [15:0] KI_LO_BW = 16'h00A0;
   localparam logic [15:0] KI_V = 16'h0004;

   // ********************************
   // types
   // ********************************
   typedef enum logic [1:0] {ST_IDLE, ST_RELAY, ST_RUN} pfcdc_phase_t;

   typedef struct packed {
      logic signed [17:0] b0;
      logic signed [17:0] b1;
      logic signed [17:0] b2;
      logic signed [17:0] a1;
      logic signed [17:0] a2;
   } pfcdc_coef_t;

   typedef struct packed {
      logic [15:0] relay_open_thr;
      logic [15:0] bw_switch_thr;
      logic [15:0] bw_hyst;
      logic [15:0] v_target;
      logic [7:0] zcd_ref_level;
   } pfcdc_cfg_t;

   typedef struct packed {
      logic signed [15:0] x1;
      logic signed [15:0] x2;
      logic signed [15:0] y1;
      logic signed [15:0] y2;
      logic vld;
   } pfcdc_bq_state_t;

   localparam int BQ_FRAC = 14;
   // sections 0,1: input smoothing filter; 2,3: bulk notch at 100 / 120 Hz
   localparam pfcdc_coef_t SECT_COEF [4] = '{
      '{18'sh0000A, 18'sh00015, 18'sh0000A, -18'sh0799A, 18'sh039C2},
      '{18'sh0000A, 18'sh00015, 18'sh0000A, -18'sh0799A, 18'sh039C2},
      '{18'sh04000, -18'sh07F67, 18'sh04000, -18'sh07CDB, 18'sh03D77},
      '{18'sh04000, -18'sh07F23, 18'sh04000, -18'sh07C98, 18'sh03D77}};

   typedef struct packed {
      logic [15:0] sw_cnt;
      logic [15:0] duty;
      logic [15:0] duty_act;
      logic [15:0] samp;
      logic pwm;
      logic samp_trig;
      logic [15:0] cap_cnt;
      logic [15:0] cap_val;
      logic cap_seen;
      logic [15:0] kcorr;
      logic [15:0] avg_cur;
      logic signed [31:0] cur_integ;
      logic high_bw;
      logic [15:0] fr_cnt;
      logic fr_trig;
      pfcdc_phase_t phase;
      logic [7:0] settle;
      logic relay;
      logic armed;
      logic signed [31:0] v_integ;
      logic [15:0] iref;
      logic cmp_s1;
      logic cmp_s2;
      logic cmp_prev;
      logic [7:0] ref_cnt;
      logic ref_pwm;
   } pfcdc_ctrl_state_t;

   function automatic logic signed [15:0] pfcdc_sat16(input logic signed [39:0] v);
      if (v > 40'sd32767) begin
         return 16'sh7FFF;
      end else if (v < -40'sd32768) begin
         return -16'sh8000;
      end
      return v[15:0];
   endfunction

endpackage

// *** rtl/pfcdc_biquad.sv ***
// pfc digital control: one second-order iir section, direct form one
`timescale 1ns/10ps
module pfcdc_biquad import pfcdc_pkg::*; #(
   parameter pfcdc_coef_t COEF = SECT_COEF[0]
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // sample in
   input wire logic in_en,
   input wire logic signed [15:0] in_x,
   // sample out
   output logic signed [15:0] out_y,
   output logic out_vld
);

   pfcdc_bq_state_t s_reg;
   pfcdc_bq_state_t s_next;
   logic signed [39:0] acc;

   always_comb begin
      s_next = s_reg;
      s_next.vld = 1'b0;
      acc = 40'(COEF.b0 * in_x) + 40'(COEF.b1 * s_reg.x1) + 40'(COEF.b2 * s_reg.x2)
          - 40'(COEF.a1 * s_reg.y1) - 40'(COEF.a2 * s_reg.y2);
      if (in_en) begin
         s_next.x2 = s_reg.x1;
         s_next.x1 = in_x;
         s_next.y2 = s_reg.y1;
         s_next.y1 = pfcdc_sat16(acc >>> BQ_FRAC);
         s_next.vld = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign out_y = s_reg.y1;
   assign out_vld = s_reg.vld;

endmodule

// *** rtl/pfcdc_ctrl.sv ***
// pfc digital control: pwm, sampling, current and voltage loops, start-up sequencing
`timescale 1ns/10ps
module pfcdc_ctrl import pfcdc_pkg::*; #(
   parameter int unsigned SWITCH_PERIOD = SWITCH_CYC,
   parameter int unsigned FIXED_RATE_PERIOD = FIXED_RATE_CYC,
   parameter logic [7:0] SETTLE_TICKS = RELAY_SETTLE_TICKS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // configuration
   input wire logic start_en,
   input wire pfcdc_cfg_t cfg,
   // converted samples
   input wire logic [15:0] cur_sample,
   input wire logic cur_sample_done,
   input wire logic signed [15:0] vin_sample,
   input wire logic signed [15:0] vbulk_sample,
   // zero-current comparator pin
   input wire logic zcd_cmp,
   // power stage
   output logic pwm_out,
   output logic relay_close,
   output logic cur_sample_trig,
   output logic zcd_ref_pwm,
   // status
   output logic fixed_rate_trigger,
   output logic [15:0] duty_compare_value,
   output logic [15:0] sample_compare_value,
   output logic [15:0] conduction_correction_factor,
   output logic [15:0] avg_current,
   output logic high_bw_sel,
   output pfcdc_phase_t phase
);

   localparam logic [15:0] PERIOD_LAST = 16'(SWITCH_PERIOD - 1);
   localparam logic [15:0] FR_LAST = 16'(FIXED_RATE_PERIOD - 1);
   localparam logic [15:0] DUTY_MAX = 16'(SWITCH_PERIOD * DUTY_MAX_PCT / 100);
   localparam logic [31:0] K_RECIP = 32'((64'd1 << 28) / SWITCH_PERIOD);

   pfcdc_ctrl_state_t s_reg;
   pfcdc_ctrl_state_t s_next;

   // ********************************
   // slow filters
   // ********************************
   logic signed [15:0] sect_y [4];
   logic sect_vld [4];

   generate
      for (genvar i = 0; i < 4; i++) begin : g_sect
         logic signed [15:0] sx;
         logic sen;
         if (i == 0) begin : g_vin
            assign sx = vin_sample;
            assign sen = s_reg.fr_trig;
         end else if (i == 2) begin : g_vbulk
            assign sx = vbulk_sample;
            assign sen = s_reg.fr_trig;
         end else begin : g_chain
            assign sx = sect_y[i-1];
            assign sen = sect_vld[i-1];
         end
         pfcdc_biquad #(.COEF(SECT_COEF[i])) u_sect (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .in_en(sen),
            .in_x(sx),
            .out_y(sect_y[i]),
            .out_vld(sect_vld[i])
         );
      end
   endgenerate

   // ********************************
   // helpers
   // ********************************
   // controller gain tracks the saturating choke: less gain as inductance drops
   function automatic logic [15:0] gain_of(input logic [15:0] cur);
      logic [31:0] drop;
      logic [31:0] base;
      drop = '0;
      base = '0;
      if (cur < CUR_SEG_SPLIT) begin
         base = {16'h0, G_ONE};
         drop = ({16'h0, SEG_A_SLOPE} * {16'h0, cur}) >> 8;
      end else begin
         base = {16'h0, SEG_B_BASE};
         drop = ({16'h0, SEG_B_SLOPE} * {16'h0, cur - CUR_SEG_SPLIT}) >> 8;
      end
      if (drop + {16'h0, G_MIN} >= base) begin
         return G_MIN;
      end
      return 16'(base - drop);
   endfunction

   function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                input logic signed [31:0] hi);
      if (v < 0) begin
         return '0;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction

   // ********************************
   // next state
   // ********************************
   logic [15:0] avg_c;
   logic [15:0] gain;
   logic [31:0] kp_eff;
   logic [31:0] ki_eff;
   logic signed [31:0] err;
   logic signed [31:0] integ_c;
   logic signed [31:0] u_c;
   logic [31:0] k_c;
   logic cmp_fall;
   logic signed [31:0] iref_c;
   logic [15:0] duty_ld;

   always_comb begin
      s_next = s_reg;
      s_next.samp_trig = 1'b0;
      s_next.fr_trig = 1'b0;
      avg_c = '0;
      gain = '0;
      kp_eff = '0;
      ki_eff = '0;
      err = '0;
      integ_c = '0;
      u_c = '0;
      k_c = '0;
      iref_c = '0;
      duty_ld = '0;

      // comparator pin through two flops before use
      s_next.cmp_s1 = zcd_cmp;
      s_next.cmp_s2 = s_reg.cmp_s1;
      s_next.cmp_prev = s_reg.cmp_s2;
      cmp_fall = s_reg.cmp_prev & ~s_reg.cmp_s2;

      // reference for the comparator; rc filter outside smooths it
      s_next.ref_cnt = s_reg.ref_cnt + 8'h01;
      s_next.ref_pwm = s_reg.ref_cnt < cfg.zcd_ref_level;

      // switching timer and capture timer
      if (s_reg.sw_cnt == PERIOD_LAST) begin
         s_next.sw_cnt = '0;
         // floor pulse keeps one conversion per period; a zero duty would never update
         duty_ld = (s_reg.duty > DUTY_MIN) ? s_reg.duty : DUTY_MIN;
         s_next.duty_act = (s_reg.phase == ST_RUN) ? duty_ld : 16'h0000;
         s_next.samp = ((s_reg.phase == ST_RUN) ? duty_ld : 16'h0000) >> 1;
         s_next.cap_cnt = '0;
         s_next.cap_seen = 1'b0;
         if (s_reg.cap_seen) begin
            k_c = ({16'h0, s_reg.cap_val} * K_RECIP) >> (28 - K_FRAC);
            s_next.kcorr = (k_c > {16'h0, K_ONE}) ? K_ONE : k_c[15:0];
         end else begin
            s_next.kcorr = K_ONE;
         end
      end else begin
         s_next.sw_cnt = s_reg.sw_cnt + 16'h0001;
         s_next.cap_cnt = s_reg.cap_cnt + 16'h0001;
      end
      if (cmp_fall && !s_reg.cap_seen && s_reg.sw_cnt != PERIOD_LAST) begin
         s_next.cap_val = s_reg.cap_cnt;
         s_next.cap_seen = 1'b1;
      end
      s_next.pwm = (s_next.sw_cnt < s_next.duty_act);
      // sample mid on-time, never while the switch is idle
      s_next.samp_trig = (s_next.duty_act != 16'h0000) && (s_next.sw_cnt == s_next.samp);

      // current loop, one update per conversion result
      if (cur_sample_done) begin
         avg_c = 16'(({16'h0, cur_sample} * {16'h0, s_reg.kcorr}) >> K_FRAC);
         s_next.avg_cur = avg_c;
         if (s_reg.high_bw
             && {1'b0, avg_c} > {1'b0, cfg.bw_switch_thr} + {1'b0, cfg.bw_hyst}) begin
            s_next.high_bw = 1'b0;
         end else if (!s_reg.high_bw && avg_c < cfg.bw_switch_thr) begin
            s_next.high_bw = 1'b1;
         end
         gain = gain_of(avg_c);
         // one fixed ccm tuning covers dcm as well; no mode detector
         kp_eff = ({16'h0, s_next.high_bw ? KP_HI_BW : KP_LO_BW} * {16'h0, gain}) >> G_FRAC;
         ki_eff = ({16'h0, s_next.high_bw ? KI_HI_BW : KI_LO_BW} * {16'h0, gain}) >> G_FRAC;
         err = $signed({16'h0, s_reg.iref}) - $signed({16'h0, avg_c});
         integ_c = clamp(s_reg.cur_integ + $signed(ki_eff) * err,
                         $signed({4'h0, DUTY_MAX, 12'h000}));
         u_c = clamp((integ_c + $signed(kp_eff) * err) >>> G_FRAC, $signed({16'h0, DUTY_MAX}));
         if (s_reg.phase == ST_RUN) begin
            s_next.cur_integ = integ_c;
            s_next.duty = u_c[15:0];
         end
      end

      // fixed-rate tick drives filters, voltage loop and sequencing
      if (s_reg.fr_cnt == FR_LAST) begin
         s_next.fr_cnt = '0;
         s_next.fr_trig = 1'b1;
      end else begin
         s_next.fr_cnt = s_reg.fr_cnt + 16'h0001;
      end

      if (s_reg.fr_trig) begin
         if (s_reg.phase == ST_RUN) begin
            s_next.v_integ = clamp(s_reg.v_integ + $signed({16'h0, KI_V})
                                   * ($signed({16'h0, cfg.v_target}) - $signed(sect_y[3])),
                                   32'sh7FFF_FFFF);
            iref_c = ($signed({16'h0, s_reg.v_integ[31:16]}) * $signed(sect_y[1])) >>> G_FRAC;
            s_next.iref = 16'(clamp(iref_c, 32'sh0000_FFFF));
         end
         unique case (s_reg.phase)
            ST_IDLE: begin
               s_next.duty = '0;
               s_next.cur_integ = '0;
               s_next.v_integ = '0;
               s_next.iref = '0;
               s_next.armed = 1'b0;
               if (start_en) begin
                  s_next.relay = 1'b1;
                  s_next.settle = '0;
                  s_next.phase = ST_RELAY;
               end
            end
            ST_RELAY: begin
               s_next.settle = s_reg.settle + 8'h01;
               if (s_reg.settle == SETTLE_TICKS) begin
                  s_next.phase = ST_RUN;
               end
            end
            ST_RUN: begin
               // the trip only arms once the bulk has risen past it, else a low-line
               // precharge would open the relay right away
               if (sect_y[3] >= $signed(cfg.relay_open_thr)) begin
                  s_next.armed = 1'b1;
               end
               if (s_reg.armed && sect_y[3] < $signed(cfg.relay_open_thr)) begin
                  s_next.relay = 1'b0;
                  s_next.duty = '0;
                  // stop the gate at once: no switching while the relay is open
                  s_next.duty_act = '0;
                  s_next.samp = '0;
                  s_next.pwm = 1'b0;
                  s_next.samp_trig = 1'b0;
                  s_next.phase = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.high_bw <= 1'b1;
         s_reg.kcorr <= K_ONE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign pwm_out = s_reg.pwm;
   assign relay_close = s_reg.relay;
   assign cur_sample_trig = s_reg.samp_trig;
   assign zcd_ref_pwm = s_reg.ref_pwm;
   assign fixed_rate_trigger = s_reg.fr_trig;
   assign duty_compare_value = s_reg.duty_act;
   assign sample_compare_value = s_reg.samp;
   assign conduction_correction_factor = s_reg.kcorr;
   assign avg_current = s_reg.avg_cur;
   assign high_bw_sel = s_reg.high_bw;
   assign phase = s_reg.phase;

endmodule

// *** dv/pfcdc_ctrl_monitor.sv ***
// assertion checker bound to the pfc control block
`timescale 1ns/10ps
module pfcdc_ctrl_monitor import pfcdc_pkg::*; #(
   parameter int unsigned FIXED_RATE_PERIOD = FIXED_RATE_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // watched inputs
   input wire pfcdc_cfg_t cfg,
   input wire logic [15:0] cur_sample,
   input wire logic cur_sample_done,
   // watched outputs
   input wire logic pwm_out,
   input wire logic relay_close,
   input wire logic cur_sample_trig,
   input wire logic fixed_rate_trigger,
   input wire logic [15:0] duty_compare_value,
   input wire logic [15:0] sample_compare_value,
   input wire logic [15:0] conduction_correction_factor,
   input wire logic [15:0] avg_current,
   input wire logic high_bw_sel,
   input wire pfcdc_phase_t phase
);
   // ****
   // helper logic
   // ****
   logic [15:0] gap_reg;
   logic seen_reg;
   logic [16:0] bw_hi;
   assign bw_hi = {1'b0, cfg.bw_switch_thr} + {1'b0, cfg.bw_hyst};
   // counter instead of a long repetition, which the tools would unroll
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_reg <= 16'h0000;
         seen_reg <= 1'b0;
      end else if (fixed_rate_trigger) begin
         gap_reg <= 16'h0001;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 16'h0001;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ****
   // properties
   // ****
   a_rate_spacing: assert property (seen_reg |-> (gap_reg <= 16'(FIXED_RATE_PERIOD))
      && (fixed_rate_trigger == (gap_reg == 16'(FIXED_RATE_PERIOD))))
      else $error("fixed-rate trigger spacing wrong");
   a_relay_first: assert property ($rose(relay_close) |-> phase == ST_RELAY && !pwm_out)
      else $error("relay closed in wrong phase or while switching");
   a_switch_run: assert property ($rose(pwm_out) |-> relay_close && phase == ST_RUN)
      else $error("switching started without relay closed in run");
   a_relay_open: assert property ($fell(relay_close) |-> phase == ST_IDLE)
      else $error("relay opened without restart to idle");
   a_half_duty: assert property (sample_compare_value == (duty_compare_value >> 1))
      else $error("sample compare is not half the duty compare");
   a_trig_on_time: assert property (cur_sample_trig |-> pwm_out ##1 !cur_sample_trig)
      else $error("current sample trigger outside on-time");
   a_avg_scaled: assert property (cur_sample_done |=> avg_current == 16'((32'($past(cur_sample))
      * 32'($past(conduction_correction_factor))) >> 14))
      else $error("average current not scaled by correction factor");
   a_kcorr_max: assert property (conduction_correction_factor <= K_ONE)
      else $error("correction factor above one");
   a_bw_drop: assert property (cur_sample_done ##1 ({1'b0, avg_current} > bw_hi)
      |-> !high_bw_sel)
      else $error("high bandwidth kept at high current");
   a_bw_raise: assert property (cur_sample_done ##1 (avg_current < cfg.bw_switch_thr)
      |-> high_bw_sel)
      else $error("high bandwidth not restored at low current");
   a_bw_hold: assert property (cur_sample_done ##1 (avg_current >= cfg.bw_switch_thr
      && {1'b0, avg_current} <= bw_hi) |-> high_bw_sel == $past(high_bw_sel))
      else $error("bandwidth toggled inside hysteresis band");
   c_relay_close: cover property ($rose(relay_close));
   c_relay_open: cover property ($fell(relay_close));
   c_bw_low: cover property ($fell(high_bw_sel));
   c_dcm: cover property (conduction_correction_factor < K_ONE);
endmodule
bind pfcdc_ctrl pfcdc_ctrl_monitor #(.FIXED_RATE_PERIOD(FIXED_RATE_PERIOD)) u_mon (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .cfg(cfg), .cur_sample(cur_sample),
   .cur_sample_done(cur_sample_done), .pwm_out(pwm_out), .relay_close(relay_close),
   .cur_sample_trig(cur_sample_trig), .fixed_rate_trigger(fixed_rate_trigger),
   .duty_compare_value(duty_compare_value), .sample_compare_value(sample_compare_value),
   .conduction_correction_factor(conduction_correction_factor), .avg_current(avg_current),
   .high_bw_sel(high_bw_sel), .phase(phase));

// *** dv/pfcdc_stage_model.sv ***
// model of the power stage: current converter and zero-current comparator
`timescale 1ns/10ps
module pfcdc_stage_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // from the controller
   input wire logic cur_sample_trig,
   input wire logic pwm_out,
   // stage condition set by the bench
   input wire logic [15:0] cur_level,
   input wire logic [7:0] conv_lat,
   input wire logic [7:0] zcd_fall,
   // to the controller
   output logic [15:0] cur_sample,
   output logic cur_sample_done,
   output logic zcd_cmp
);
   logic [7:0] conv_cnt;
   logic busy;
   logic [7:0] on_cnt;
   logic pwm_prev;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         conv_cnt <= 8'h00;
         busy <= 1'b0;
         cur_sample <= 16'h0000;
         cur_sample_done <= 1'b0;
         on_cnt <= 8'hFF;
         pwm_prev <= 1'b0;
         zcd_cmp <= 1'b1;
      end else begin
         cur_sample_done <= 1'b0;
         pwm_prev <= pwm_out;
         if (cur_sample_trig) begin
            busy <= 1'b1;
            conv_cnt <= conv_lat;
         end else if (busy && conv_cnt == 8'h00) begin
            busy <= 1'b0;
            cur_sample <= cur_level;
            cur_sample_done <= 1'b1;
         end else if (busy) begin
            conv_cnt <= conv_cnt - 8'h01;
         end else begin
            // result is not held once the done pulse is over
            cur_sample <= ~cur_sample;
         end
         // zero fall delay models continuous conduction: comparator never drops
         if (pwm_out && !pwm_prev) begin
            on_cnt <= 8'h00;
            zcd_cmp <= 1'b1;
         end else if (on_cnt != 8'hFF) begin
            on_cnt <= on_cnt + 8'h01;
            if (zcd_fall != 8'h00 && on_cnt == zcd_fall) begin
               zcd_cmp <= 1'b0;
            end
         end
      end
   end
endmodule

// *** dv/pfcdc_ctrl_tb.sv ***
// self-checking bench for the pfc control block
`timescale 1ns/10ps
module pfcdc_ctrl_tb import pfcdc_pkg::*; ;
   localparam int unsigned SW_P = 100;
   localparam int unsigned FR_P = 200;
   localparam int LIMIT = 95000;
   logic ref_clk, sys_rst, start_en, cur_sample_done, zcd_cmp;
   pfcdc_cfg_t cfg;
   logic signed [15:0] vin_sample, vbulk_sample;
   logic [15:0] cur_level, cur_sample;
   logic [7:0] conv_lat, zcd_fall;
   logic pwm_out, relay_close, cur_sample_trig, zcd_ref_pwm, fixed_rate_trigger, high_bw_sel;
   logic [15:0] duty_compare_value, sample_compare_value, conduction_correction_factor;
   logic [15:0] avg_current;
   pfcdc_phase_t phase;
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   pfcdc_ctrl #(.SWITCH_PERIOD(SW_P), .FIXED_RATE_PERIOD(FR_P), .SETTLE_TICKS(8'h02)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .start_en(start_en), .cfg(cfg),
      .cur_sample(cur_sample), .cur_sample_done(cur_sample_done), .vin_sample(vin_sample),
      .vbulk_sample(vbulk_sample), .zcd_cmp(zcd_cmp), .pwm_out(pwm_out),
      .relay_close(relay_close), .cur_sample_trig(cur_sample_trig), .zcd_ref_pwm(zcd_ref_pwm),
      .fixed_rate_trigger(fixed_rate_trigger), .duty_compare_value(duty_compare_value),
      .sample_compare_value(sample_compare_value),
      .conduction_correction_factor(conduction_correction_factor),
      .avg_current(avg_current), .high_bw_sel(high_bw_sel), .phase(phase));
   pfcdc_stage_model u_stage (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .cur_sample_trig(cur_sample_trig),
      .pwm_out(pwm_out), .cur_level(cur_level), .conv_lat(conv_lat), .zcd_fall(zcd_fall),
      .cur_sample(cur_sample), .cur_sample_done(cur_sample_done), .zcd_cmp(zcd_cmp));
   // ****
   // clock, timeout and shared tasks
   // ****
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         mismatches++;
         $display("CHECK FAILED timeout expected %0d seen %0d", LIMIT, cyc);
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input logic [15:0] lo, input logic [15:0] hi,
                          input logic [15:0] got);
      checked++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h..%h seen %h", what, lo, hi, got);
      end
   endtask
   task automatic wait_done();
      for (int i = 0; i < 400 && cur_sample_done !== 1'b1; i++) tick(1);
      tick(1);
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset();
      chk("relay_close", 16'h0000, relay_close);
      chk("pwm_out", 16'h0000, pwm_out);
      chk("high_bw_sel", 16'h0001, high_bw_sel);
      chk("conduction_correction_factor", K_ONE, conduction_correction_factor);
   endtask
   task automatic t_start();
      int i, n;
      logic early;
      early = 1'b0;
      for (i = 0; i < 400 && fixed_rate_trigger !== 1'b1; i++) tick(1);
      tick(1);
      for (n = 1; n < 400 && fixed_rate_trigger !== 1'b1; n++) tick(1);
      chk("fixed_rate_gap", 16'(FR_P), 16'(n));
      start_en = 1'b1;
      for (i = 0; i < 3000 && phase !== ST_RUN; i++) begin
         early |= pwm_out;
         tick(1);
      end
      chk("pwm_before_run", 16'h0000, 16'(early));
      chk("relay_close", 16'h0001, relay_close);
      chk("phase", 16'(ST_RUN), 16'(phase));
   endtask
   task automatic t_ref();
      int n;
      n = 0;
      repeat (256) begin
         n += int'(zcd_ref_pwm === 1'b1);
         tick(1);
      end
      chk("zcd_ref_high_cycles", 16'h0020, 16'(n));
   endtask
   task automatic t_sample();
      int i, w, t;
      logic [15:0] d;
      for (i = 0; i < 40000 && !(duty_compare_value > 16'h0004); i++) tick(1);
      for (i = 0; i < 200 && pwm_out !== 1'b0; i++) tick(1);
      for (i = 0; i < 200 && pwm_out !== 1'b1; i++) tick(1);
      d = duty_compare_value;
      chk_rng("duty_ramp", 16'h0005, 16'(SW_P), d);
      chk("sample_compare_value", d >> 1, sample_compare_value);
      t = -1;
      for (w = 0; w < 200 && pwm_out === 1'b1; w++) begin
         if (cur_sample_trig === 1'b1) t = w;
         tick(1);
      end
      chk("pwm_width", d, 16'(w));
      chk("trig_offset", d >> 1, 16'(t));
   endtask
   task automatic t_kcorr();
      zcd_fall = 8'd30;
      tick(3 * SW_P);
      chk_rng("kcorr_dcm", 16'd4915, 16'd6554, conduction_correction_factor);
      zcd_fall = 8'd0;
      conv_lat = 8'd0;
      cur_level = 16'h0021;
      tick(3 * SW_P);
      chk("kcorr_ccm", K_ONE, conduction_correction_factor);
      wait_done();
      chk("avg_current", 16'h0021, avg_current);
   endtask
   task automatic t_bw();
      logic [15:0] lv [6] = '{16'h0080, 16'h0068, 16'h0050, 16'h0068, 16'h0070, 16'h0071};
      logic ex [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 6; i++) begin
         cur_level = lv[i];
         wait_done();
         wait_done();
         chk("high_bw_sel", 16'(ex[i]), 16'(high_bw_sel));
      end
   endtask
   task automatic t_trip();
      int i;
      vbulk_sample = 16'sh1000;
      for (i = 0; i < 30000 && relay_close !== 1'b0; i++) tick(1);
      chk("relay_close", 16'h0000, relay_close);
      chk("phase", 16'(ST_IDLE), 16'(phase));
      vbulk_sample = 16'sh18B0;
      for (i = 0; i < 3000 && relay_close !== 1'b1; i++) tick(1);
      chk("relay_restart", 16'h0001, relay_close);
   endtask
   initial begin
      sys_rst = 1'b1;
      start_en = 1'b0;
      cfg = '{16'h14D0, 16'h0060, 16'h0010, 16'h1C00, 8'h20};
      vin_sample = 16'sh0C00;
      vbulk_sample = 16'sh18B0;
      cur_level = 16'h0000;
      conv_lat = 8'd20;
      zcd_fall = 8'd0;
      tick(10);
      t_reset();
      tick(10);
      sys_rst = 1'b0;
      t_start();
      t_ref();
      t_sample();
      t_kcorr();
      t_bw();
      t_trip();
      give_verdict();
   end
endmodule
